/* File: src/dces_apb_slave.sv */
// apb slave front end: decodes an access into one-cycle read/write strobes
`timescale 1ns/1ps
`default_nettype none
`include "dces_map.svh"

module dces_apb_slave
  import dces_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // apb
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  output logic             o_pready,
  output logic             o_pslverr,
  // register side
  output logic             o_wr,
  output logic             o_rd,
  output logic [7:0]       o_idx,
  input  wire logic        i_hit
);
  import dces_pkg::*;

  dces_apb_state_t state;
  dces_apb_state_t next_state;

  // access completes in its first access cycle: zero wait states
  wire access = i_psel && i_penable;

  always_comb
  begin
    case (state)
      DCES_APB_IDLE:   next_state = i_psel ? DCES_APB_SETUP : DCES_APB_IDLE;
      DCES_APB_SETUP:  next_state = DCES_APB_ACCESS;
      DCES_APB_ACCESS: next_state = i_psel ? DCES_APB_SETUP : DCES_APB_IDLE;
      default:         next_state = DCES_APB_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      state <= DCES_APB_IDLE;
    else
      state <= (access) ? (i_psel && !i_penable ? DCES_APB_SETUP : DCES_APB_IDLE) : next_state;
  end

  assign o_pready  = access;
  assign o_pslverr = access && !i_hit;
  assign o_wr      = access && i_pwrite && i_hit;
  assign o_rd      = access && !i_pwrite;
  assign o_idx     = i_paddr[9:2];

endmodule // dces_apb_slave
`default_nettype wire

/* File: src/dces_chan_status.sv */
// per-channel event controls, interrupt enables, flags and status behind apb
//
// Summary of operation
// - event output enable gates channel event generation
// - event input enable gates incoming event action
// - action runs only with own channel enabled
// - actions 0-3: none, strobe, conditional, conditional block
// - actions 4-6: suspend, resume, skip suspend; 7 reserved
// - event controls exist only on low channels
// - enable clear write-1 clears, mirrors set register
// - enable set write-1 sets, mirrors clear register
// - enable, flag, status act on selected channel
// - suspend bit2, complete bit1, error bit0; reset zero
// - suspend flag: block suspend, command, event, bad descriptor
// - complete flag on block end with irq action
// - block action none leaves complete flag alone
// - error flag on bus error or bad descriptor
// - flags cleared only by writing one
// - fetch error set on bad fetch, cleared by resume command
// - busy set on start, cleared on done/error/disable
// - pending set on request, cleared on start/error/disable
// - command codes: none, suspend, resume, reserved
`timescale 1ns/1ps
`default_nettype none
`include "dces_map.svh"

module dces_chan_status
  import dces_pkg::*;
(
  // clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst,
  // apb slave
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [11:0]             i_paddr,
  input  wire logic [31:0]             i_pwdata,
  input  wire logic [3:0]              i_pstrb,
  output logic [31:0]                  o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  // event routing system
  input  wire logic [7:0]              i_event_in,
  output logic [7:0]                   o_event_out,
  // transfer engine
  input  wire dces_pkg::dces_engine_ev_t i_eng,
  input  wire logic [7:0]              i_eng_event_cond,
  output dces_pkg::dces_ev_act_t       o_ev_act,
  output dces_pkg::dces_sw_cmd_t       o_sw_cmd,
  output logic [7:0]                   o_chan_irq,
  output logic [7:0]                   o_chan_busy,
  output logic [7:0]                   o_chan_pending
);
  import dces_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [2:0]  chan_select;
  logic [31:0] ctrl_b   [`DCES_NUM_CHAN];
  logic [2:0]  irq_en   [`DCES_NUM_CHAN];
  logic [2:0]  irq_flag [`DCES_NUM_CHAN];
  logic [2:0]  status   [`DCES_NUM_CHAN];
  logic [7:0]  ev_meta;
  logic [7:0]  ev_sync;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic       wr;
  logic       rd;
  logic [7:0] idx;

  wire hit_sel  = (idx == `DCES_IDX_CHAN_SEL);
  wire hit_ctlb = (idx == `DCES_IDX_CTRLB);
  wire hit_clr  = (idx == `DCES_IDX_IRQ_EN_CLR);
  wire hit_set  = (idx == `DCES_IDX_IRQ_EN_SET);
  wire hit_flg  = (idx == `DCES_IDX_IRQ_FLAGS);
  wire hit_sts  = (idx == `DCES_IDX_STATUS);
  wire hit      = hit_sel || hit_ctlb || hit_clr || hit_set || hit_flg || hit_sts;

  dces_apb_slave u_apb
  (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_psel    (i_psel),
    .i_penable (i_penable),
    .i_pwrite  (i_pwrite),
    .i_paddr   (i_paddr),
    .o_pready  (o_pready),
    .o_pslverr (o_pslverr),
    .o_wr      (wr),
    .o_rd      (rd),
    .o_idx     (idx),
    .i_hit     (hit)
  );

  // byte lane 0 carries the narrow registers
  wire       lane0 = i_pstrb[0];
  wire [2:0] wbits = i_pwdata[2:0];

  // merges byte-enabled write data into a 32-bit word
  function automatic logic [31:0] merge_word(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[b*8 +: 8] = data[b*8 +: 8];
    return res;
  endfunction

  // a channel's one-hot select mask
  function automatic logic [7:0] sel_mask(input logic [2:0] ch);
    return 8'h01 << ch;
  endfunction

  wire [7:0] sel_oh  = sel_mask(chan_select);
  wire       w_ctlb  = wr && hit_ctlb;
  wire       w_clr   = wr && hit_clr && lane0;
  wire       w_set   = wr && hit_set && lane0;
  wire       w_flg   = wr && hit_flg && lane0;

  // ---------------------------------------------------------------
  // software command, issued by the write that carries it
  // ---------------------------------------------------------------
  wire [1:0] cmd_code = i_pwdata[`DCES_CTRLB_CMD_LO +: 2];
  wire       cmd_ok   = w_ctlb && i_pstrb[3];
  wire       is_suspend = cmd_ok && dces_cmd_t'(cmd_code) == DCES_CMD_SUSPEND;
  wire       is_resume  = cmd_ok && dces_cmd_t'(cmd_code) == DCES_CMD_RESUME;
  wire [7:0] sw_suspend = is_suspend ? sel_oh : '0;
  wire [7:0] sw_res     = is_resume ? sel_oh : '0;

  // ---------------------------------------------------------------
  // event inputs: two-stage synchroniser, then decode
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      ev_meta <= `DCES_RST_BYTE;
      ev_sync <= `DCES_RST_BYTE;
    end
    else
    begin
      ev_meta <= i_event_in;
      ev_sync <= ev_meta;
    end
  end

  logic [7:0]  ev_in_en;
  logic [23:0] ev_action;
  logic [7:0]  ev_out_en;

  always_comb
  begin
    ev_in_en  = '0;
    ev_action = '0;
    ev_out_en = '0;
    for (int c = 0; c < `DCES_NUM_EVCHAN; c++)
    begin
      ev_in_en[c]         = ctrl_b[c][`DCES_CTRLB_IN_EN];
      ev_action[c*3 +: 3] = ctrl_b[c][`DCES_CTRLB_ACTION_LO +: 3];
      ev_out_en[c]        = ctrl_b[c][`DCES_CTRLB_OUT_EN];
    end
  end

  dces_event_decode u_evdec
  (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_in_enable (ev_in_en),
    .i_action    (ev_action),
    .i_event     (ev_sync),
    .o_act       (o_ev_act)
  );

  // ---------------------------------------------------------------
  // per-channel state
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      chan_select <= `DCES_ZERO3;
    else if (wr && hit_sel && lane0)
      chan_select <= i_pwdata[2:0];
  end

  for (genvar c = 0; c < `DCES_NUM_CHAN; c++)
  begin : g_chan
    wire sel = sel_oh[c];

    // event control bits only stored on the low channels
    wire [31:0] ctl_mask = (c < `DCES_NUM_EVCHAN) ? 32'hffff_ffff
                                                  : ~`DCES_CTRLB_EVMASK;

    // flag set terms
    wire set_suspend = (i_eng.block_done[c] && i_eng.block_suspend_act[c])
                       || sw_suspend[c] || o_ev_act.suspend[c] || i_eng.bad_desc[c];
    // block action none gives no irq action, so no set here
    wire set_tdone   = i_eng.block_done[c] && i_eng.block_irq_act[c];
    wire set_error   = i_eng.bus_error[c] || i_eng.bad_desc[c];
    wire [2:0] flag_set = {set_suspend, set_tdone, set_error};
    wire [2:0] flag_clr = (w_flg && sel) ? wbits : 3'h0;

    wire [2:0] en_clr = (w_clr && sel) ? wbits : 3'h0;
    wire [2:0] en_set = (w_set && sel) ? wbits : 3'h0;

    // status terms: set wins over a clear in the same cycle
    wire stop_busy    = i_eng.trigger_done[c] || i_eng.bus_error[c] || i_eng.chan_disable[c];
    wire stop_pending = i_eng.trigger_start[c] || i_eng.bus_error[c] || i_eng.chan_disable[c];
    wire next_fetch_err = i_eng.bad_desc[c]
                          || (status[c][`DCES_BIT_FETCH_ERR] && !sw_res[c]);
    wire next_busy      = i_eng.xfer_start[c]
                          || (status[c][`DCES_BIT_BUSY] && !stop_busy);
    wire next_pending   = i_eng.request[c]
                          || (status[c][`DCES_BIT_PENDING] && !stop_pending);

    always_ff @(posedge i_ref_clk)
    begin
      if (i_rst)
      begin
        ctrl_b[c]   <= `DCES_RST_WORD;
        irq_en[c]   <= `DCES_ZERO3;
        irq_flag[c] <= `DCES_ZERO3;
        status[c]   <= `DCES_ZERO3;
      end
      else
      begin
        if (w_ctlb && sel)
          ctrl_b[c] <= merge_word(ctrl_b[c], i_pwdata, i_pstrb) & ctl_mask;
        irq_en[c]   <= (irq_en[c] & ~en_clr) | en_set;
        irq_flag[c] <= (irq_flag[c] & ~flag_clr) | flag_set;
        status[c]   <= {next_fetch_err, next_busy, next_pending};
      end
    end

    assign o_chan_irq[c]  = |(irq_flag[c] & irq_en[c]);
    assign o_chan_busy[c] = status[c][`DCES_BIT_BUSY];
    assign o_chan_pending[c] = status[c][`DCES_BIT_PENDING];
  end

  // ---------------------------------------------------------------
  // event outputs and command pulses
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_event_out <= `DCES_RST_BYTE;
      o_sw_cmd    <= '0;
    end
    else
    begin
      o_event_out <= i_eng_event_cond & ev_out_en;
      o_sw_cmd    <= {sw_suspend, sw_res};
    end
  end

  // ---------------------------------------------------------------
  // read data, selected channel only
  // ---------------------------------------------------------------
  wire [31:0] rd_word =
      hit_sel  ? {29'h0, chan_select} :
      hit_ctlb ? {6'h0, ctrl_b[chan_select][25:0]} :
      hit_clr  ? {29'h0, irq_en[chan_select]} :
      hit_set  ? {29'h0, irq_en[chan_select]} :
      hit_flg  ? {29'h0, irq_flag[chan_select]} :
      hit_sts  ? {29'h0, status[chan_select]} : 32'h0;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_prdata <= `DCES_RST_WORD;
    else if (i_psel && !i_penable && !i_pwrite)
      o_prdata <= rd_word;
  end

  wire unused_rd = rd;

endmodule // dces_chan_status
`default_nettype wire

/* File: src/dces_event_decode.sv */
// event input action decode for the event-capable channels
`timescale 1ns/1ps
`default_nettype none
`include "dces_map.svh"

module dces_event_decode
  import dces_pkg::*;
(
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  // configuration, per channel
  input  wire logic [7:0]   i_in_enable,
  input  wire logic [23:0]  i_action,
  // incoming events, already synchronised
  input  wire logic [7:0]   i_event,
  // decoded actions
  output dces_pkg::dces_ev_act_t o_act
);
  import dces_pkg::*;

  dces_ev_act_t next_act;

  always_comb
  begin
    next_act = '0;
    for (int c = 0; c < `DCES_NUM_EVCHAN; c++)
    begin
      // an event only acts when its own channel's input enable is set
      if (i_event[c] && i_in_enable[c])
      begin
        case (dces_event_action_t'(i_action[c*3 +: 3]))
          DCES_EV_STROBE_TRIGGER: next_act.strobe_trigger[c] = 1'b1;
          DCES_EV_COND_TRIGGER:   next_act.cond_trigger[c]   = 1'b1;
          DCES_EV_COND_BLOCK:     next_act.cond_block[c]     = 1'b1;
          DCES_EV_SUSPEND:        next_act.suspend[c]        = 1'b1;
          DCES_EV_RESUME:         next_act.resume[c]         = 1'b1;
          DCES_EV_SKIP_SUSPEND:   next_act.skip_suspend[c]   = 1'b1;
          default:                next_act.suspend[c]        = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_act <= '0;
    else
      o_act <= next_act;
  end

endmodule // dces_event_decode
`default_nettype wire

/* File: src/dces_map.svh */
// register offsets, field positions and reset values of the channel event/irq/status block
`ifndef DCES_MAP_SVH
`define DCES_MAP_SVH

// register indices; byte address is four times the index
`define DCES_IDX_CTRLB       8'h44
`define DCES_IDX_IRQ_EN_CLR  8'h4c
`define DCES_IDX_IRQ_EN_SET  8'h4d
`define DCES_IDX_IRQ_FLAGS   8'h4e
`define DCES_IDX_STATUS      8'h4f
`define DCES_IDX_CHAN_SEL    8'h3f

`define DCES_NUM_CHAN        8
`define DCES_NUM_EVCHAN      4
`define DCES_CHW             3

`define DCES_BIT_SUSPEND     2
`define DCES_BIT_TDONE       1
`define DCES_BIT_XFER_ERR    0
`define DCES_BIT_FETCH_ERR   2
`define DCES_BIT_BUSY        1
`define DCES_BIT_PENDING     0

`define DCES_CTRLB_ACTION_LO 0
`define DCES_CTRLB_IN_EN     3
`define DCES_CTRLB_OUT_EN    4
`define DCES_CTRLB_CMD_LO    24
`define DCES_CTRLB_EVMASK    32'h0000_001f

`define DCES_RST_BYTE        8'h00
`define DCES_RST_WORD        32'h0000_0000
`define DCES_ZERO3           3'h0

`endif

/* File: src/dces_pkg.sv */
// types shared by the channel event/irq/status block
`default_nettype none
package dces_pkg;

  typedef enum logic [2:0] {
    DCES_EV_NO_ACTION   = 3'h0,
    DCES_EV_STROBE_TRIGGER = 3'h1,
    DCES_EV_COND_TRIGGER   = 3'h2,
    DCES_EV_COND_BLOCK     = 3'h3,
    DCES_EV_SUSPEND        = 3'h4,
    DCES_EV_RESUME         = 3'h5,
    DCES_EV_SKIP_SUSPEND   = 3'h6,
    DCES_EV_RESERVED       = 3'h7
  } dces_event_action_t;

  typedef enum logic [1:0] {
    DCES_CMD_NO_ACTION = 2'h0,
    DCES_CMD_SUSPEND   = 2'h1,
    DCES_CMD_RESUME    = 2'h2,
    DCES_CMD_RESERVED  = 2'h3
  } dces_cmd_t;

  typedef enum logic [1:0] {
    DCES_APB_IDLE   = 2'b00,
    DCES_APB_SETUP  = 2'b01,
    DCES_APB_ACCESS = 2'b11
  } dces_apb_state_t;

  // per-channel engine happenings, one-cycle pulses, one bit per channel
  typedef struct packed {
    logic [7:0] block_done;
    logic [7:0] block_irq_act;
    logic [7:0] block_suspend_act;
    logic [7:0] bus_error;
    logic [7:0] bad_desc;
    logic [7:0] xfer_start;
    logic [7:0] trigger_done;
    logic [7:0] request;
    logic [7:0] trigger_start;
    logic [7:0] chan_disable;
  } dces_engine_ev_t;

  // decoded event actions toward the engine, one-cycle pulses
  typedef struct packed {
    logic [7:0] strobe_trigger;
    logic [7:0] cond_trigger;
    logic [7:0] cond_block;
    logic [7:0] suspend;
    logic [7:0] resume;
    logic [7:0] skip_suspend;
  } dces_ev_act_t;

  typedef struct packed {
    logic [7:0] suspend;
    logic [7:0] resume;
  } dces_sw_cmd_t;

endpackage
`default_nettype wire

/* File: verif/dces_chan_status_sva.sv */
// assertion checker for the channel event/irq/status block
`timescale 1ns/1ps
`default_nettype none
module dces_chan_status_sva
(
  // clock and reset
  input wire logic                      i_ref_clk,
  input wire logic                      i_rst,
  // apb
  input wire logic                      i_psel,
  input wire logic                      i_penable,
  input wire logic                      i_pwrite,
  input wire logic [11:0]               i_paddr,
  input wire logic [31:0]               i_pwdata,
  input wire logic [3:0]                i_pstrb,
  input wire logic                      o_pslverr,
  // events and engine
  input wire logic [7:0]                i_event_in,
  input wire logic [7:0]                o_event_out,
  input wire dces_pkg::dces_engine_ev_t i_eng,
  input wire logic [7:0]                i_eng_event_cond,
  input wire dces_pkg::dces_ev_act_t    o_ev_act,
  input wire dces_pkg::dces_sw_cmd_t    o_sw_cmd,
  input wire logic [7:0]                o_chan_busy,
  input wire logic [7:0]                o_chan_pending
);
  import dces_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  wire logic       cmd_wr = i_psel && i_penable && i_pwrite && i_paddr == 12'h110 && i_pstrb[3];
  wire logic [7:0] any_act = o_ev_act.strobe_trigger | o_ev_act.cond_trigger | o_ev_act.cond_block
                           | o_ev_act.suspend | o_ev_act.resume | o_ev_act.skip_suspend;
  for (genvar c = 0; c < 8; c++)
  begin : g_ch
    busy_set_a: assert property (i_eng.xfer_start[c] |=> o_chan_busy[c])
      else $error("busy not set after start");
    busy_clr_a: assert property ((i_eng.trigger_done[c] || i_eng.bus_error[c]
      || i_eng.chan_disable[c]) && !i_eng.xfer_start[c] |=> !o_chan_busy[c])
      else $error("busy not cleared");
    busy_hold_a: assert property (!(i_eng.xfer_start[c] || i_eng.trigger_done[c]
      || i_eng.bus_error[c] || i_eng.chan_disable[c]) |=> $stable(o_chan_busy[c]))
      else $error("busy moved without cause");
    pending_set_a: assert property (i_eng.request[c] |=> o_chan_pending[c])
      else $error("pending not set after request");
    pending_clr_a: assert property ((i_eng.trigger_start[c] || i_eng.bus_error[c]
      || i_eng.chan_disable[c]) && !i_eng.request[c] |=> !o_chan_pending[c])
      else $error("pending not cleared");
    evout_cause_a: assert property (o_event_out[c] |-> $past(i_eng_event_cond[c]))
      else $error("event out without condition");
    event_cause_a: assert property (any_act[c] |-> $past(i_event_in[c], 3))
      else $error("event action without input event");
  end
  hi_chan_a: assert property (any_act[7:4] == 4'h0 && o_event_out[7:4] == 4'h0)
    else $error("event logic active on upper channel");
  cmd_set_a: assert property (cmd_wr && i_pwdata[25:24] == 2'h1 |=> |o_sw_cmd.suspend)
    else $error("suspend command not issued");
  cmd_cause_a: assert property (|o_sw_cmd.resume |->
    $past(cmd_wr && i_pwdata[25:24] == 2'h2))
    else $error("resume command without write");
  pslverr_a: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("slave error outside access phase");
  cover property (|o_sw_cmd.resume);
  cover property (o_ev_act.skip_suspend[1]);
  cover property (o_pslverr);
endmodule // dces_chan_status_sva
bind dces_chan_status dces_chan_status_sva chk_u (
  .i_ref_clk        (i_ref_clk),
  .i_rst            (i_rst),
  .i_psel           (i_psel),
  .i_penable        (i_penable),
  .i_pwrite         (i_pwrite),
  .i_paddr          (i_paddr),
  .i_pwdata         (i_pwdata),
  .i_pstrb          (i_pstrb),
  .o_pslverr        (o_pslverr),
  .i_event_in       (i_event_in),
  .o_event_out      (o_event_out),
  .i_eng            (i_eng),
  .i_eng_event_cond (i_eng_event_cond),
  .o_ev_act         (o_ev_act),
  .o_sw_cmd         (o_sw_cmd),
  .o_chan_busy      (o_chan_busy),
  .o_chan_pending   (o_chan_pending)
);
`default_nettype wire

/* File: verif/dces_far_model.sv */
// far side model: transfer engine pulses and event routing lines
`timescale 1ns/1ps
`default_nettype none
module dces_far_model
(
  // clock
  input  wire logic                 i_ref_clk,
  // toward the block
  output dces_pkg::dces_engine_ev_t o_eng,
  output logic [7:0]                o_event,
  output logic [7:0]                o_cond
);
  import dces_pkg::*;
  logic [79:0] eng_vec = '0;
  assign o_eng = eng_vec;
  initial o_event = 8'h00;
  initial o_cond = 8'h00;
  // ----------------------------------------
  // one-cycle pulses; mask bit 0 is chan_disable, bit 9 block_done
  // ----------------------------------------
  task automatic fire(input logic [9:0] f, input int ch);
    @(posedge i_ref_clk);
    for (int k = 0; k < 10; k++)
      eng_vec[k*8+ch] <= f[k];
    @(posedge i_ref_clk);
    eng_vec <= '0;
    @(negedge i_ref_clk);
  endtask
  task automatic pulse(input logic is_cond, input int ch);
    @(posedge i_ref_clk);
    if (is_cond)
      o_cond[ch] <= 1'b1;
    else
      o_event[ch] <= 1'b1;
    @(posedge i_ref_clk);
    o_event <= 8'h00;
    o_cond <= 8'h00;
  endtask
endmodule // dces_far_model
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the channel event/irq/status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module tb;
  import dces_pkg::*;
  localparam logic [11:0] SEL = 12'h0fc, CTB = 12'h110, CLR = 12'h130, SET = 12'h134;
  localparam logic [11:0] FLG = 12'h138, STS = 12'h13c;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]     paddr = '0;
  logic [31:0]     pwdata = '0, prdata, q;
  logic [3:0]      pstrb = 4'hf;
  logic            pready, pslverr, err;
  logic [7:0]      ev_in, ev_out, cond, irq, busy, pending;
  dces_engine_ev_t eng;
  dces_ev_act_t    act;
  dces_sw_cmd_t    cmd;
  int              n_errors = 0, n_compared = 0, cycles = 0;
  initial forever #5 clk = ~clk;
  dces_chan_status dut_u (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_event_in(ev_in), .o_event_out(ev_out),
    .i_eng(eng), .i_eng_event_cond(cond), .o_ev_act(act), .o_sw_cmd(cmd), .o_chan_irq(irq),
    .o_chan_busy(busy), .o_chan_pending(pending));
  dces_far_model far_u (.i_ref_clk(clk), .o_eng(eng), .o_event(ev_in), .o_cond(cond));
  // ----------------------------------------
  // bus and report tasks
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    apb(1'b0, a, '0);
    `CHK(nm, e, q)
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdchk("enable clear", CLR, 32'h0);
    rdchk("enable set", SET, 32'h0);
    rdchk("flags", FLG, 32'h0);
    rdchk("status", STS, 32'h0);
    rdchk("unmapped", 12'h004, 32'h0);
    `CHK("unmapped error", 1'b1, err)
  endtask
  task automatic t_enables();
    apb(1'b1, SEL, 32'h2);
    apb(1'b1, SET, 32'h5);
    rdchk("set reg", SET, 32'h5);
    rdchk("clear mirror", CLR, 32'h5);
    apb(1'b1, CLR, 32'h1);
    rdchk("set after clear", SET, 32'h4);
    apb(1'b1, SET, 32'h0);
    rdchk("set zero write", SET, 32'h4);
    apb(1'b1, SEL, 32'h3);
    rdchk("other channel", SET, 32'h0);
    apb(1'b1, SET, 32'h2);
    apb(1'b1, SEL, 32'h2);
    rdchk("own channel", CLR, 32'h4);
    apb(1'b1, SET, 32'h1);
  endtask
  task automatic t_flags();
    far_u.fire(10'h040, 2);
    rdchk("error flag", FLG, 32'h1);
    `CHK("irq on error", 1'b1, irq[2])
    far_u.fire(10'h200, 2);
    rdchk("block no action", FLG, 32'h1);
    far_u.fire(10'h300, 2);
    rdchk("done flag", FLG, 32'h3);
    apb(1'b1, FLG, 32'h0);
    rdchk("write zero", FLG, 32'h3);
    apb(1'b1, FLG, 32'h1);
    rdchk("write one", FLG, 32'h2);
    `CHK("irq masked", 1'b0, irq[2])
    far_u.fire(10'h280, 2);
    rdchk("block suspend", FLG, 32'h6);
    `CHK("irq on suspend", 1'b1, irq[2])
    apb(1'b1, FLG, 32'h7);
    far_u.fire(10'h020, 2);
    rdchk("bad descriptor", FLG, 32'h5);
    rdchk("fetch error", STS, 32'h4);
    apb(1'b1, FLG, 32'h7);
  endtask
  task automatic t_cmd();
    apb(1'b1, CTB, 32'h0300_0000);
    rdchk("reserved cmd", FLG, 32'h0);
    rdchk("reserved keeps status", STS, 32'h4);
    apb(1'b1, CTB, 32'h0100_0000);
    rdchk("suspend cmd", FLG, 32'h4);
    apb(1'b1, CTB, 32'h0200_0000);
    rdchk("resume cmd", STS, 32'h0);
    apb(1'b1, FLG, 32'h7);
  endtask
  task automatic t_status();
    logic [9:0] m [8] = '{10'h004, 10'h010, 10'h002, 10'h008, 10'h014, 10'h040, 10'h014, 10'h001};
    logic [1:0] e [8] = '{2'b01, 2'b11, 2'b10, 2'b00, 2'b11, 2'b00, 2'b11, 2'b00};
    for (int k = 0; k < 8; k++)
    begin
      far_u.fire(m[k], 2);
      `CHK("busy pending", e[k], {busy[2], pending[2]})
    end
    far_u.fire(10'h014, 2);
    rdchk("status busy request_pending", STS, 32'h3);
    far_u.fire(10'h001, 2);
  endtask
  task automatic watch(input logic c, input int ch, output logic [6:0] s);
    s = '0;
    far_u.pulse(c, ch);
    repeat (6)
    begin
      @(negedge clk);
      s |= {ev_out[ch], act.strobe_trigger[ch], act.cond_trigger[ch], act.cond_block[ch],
            act.suspend[ch], act.resume[ch], act.skip_suspend[ch]};
    end
  endtask
  task automatic t_events();
    logic [6:0] s;
    apb(1'b1, SEL, 32'h1);
    for (int a = 0; a < 8; a++)
    begin
      apb(1'b1, CTB, 32'h8 | a);
      watch(1'b0, 1, s);
      `CHK("event action", (a > 0 && a < 7) ? 7'h40 >> a : 7'h0, s)
    end
    apb(1'b1, CTB, 32'h4);
    watch(1'b0, 1, s);
    `CHK("input disabled", 7'h0, s)
    apb(1'b1, CTB, 32'h10);
    watch(1'b1, 1, s);
    `CHK("event out on", 7'h40, s)
    apb(1'b1, CTB, 32'h0);
    watch(1'b1, 1, s);
    `CHK("event out off", 7'h0, s)
    apb(1'b1, SEL, 32'h5);
    apb(1'b1, CTB, 32'h1c);
    rdchk("upper channel ctrl", CTB, 32'h0);
    watch(1'b0, 5, s);
    `CHK("upper channel event", 7'h0, s)
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_enables();
    t_flags();
    t_cmd();
    t_status();
    t_events();
    close_out();
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      close_out();
    end
  end
endmodule // tb
`default_nettype wire
